/* File: logic/dfcp_consts.svh */
// constants shared by both ends of the dual format control port
`ifndef DFCP_CONSTS_SVH
`define DFCP_CONSTS_SVH
// address pointer layout
`define DFCP_PTR_INC_BIT 7
`define DFCP_PTR_RESET 8'h00
// bus addresses
`define DFCP_TW_ADDR_HI 5'h13
`define DFCP_FW_ADDR 7'h4C
// device register indices
`define DFCP_REG_ID 4'h1
`define DFCP_REG_FIRST_RW 4'h2
`define DFCP_REG_MISC 4'h8
`define DFCP_REG_LAST 4'h9
`define DFCP_MISC_PDN_BIT 7
`define DFCP_MISC_EN_BIT 6
// device register reset values
`define DFCP_RST_R2 8'h00
`define DFCP_RST_R3 8'h09
`define DFCP_RST_R4 8'hC0
`define DFCP_RST_R5 8'h00
`define DFCP_RST_R6 8'h00
`define DFCP_RST_R7 8'hB0
`define DFCP_RST_R8 8'h80
`define DFCP_RST_R9 8'h08
// stand-alone power-up delay in link clock cycles
`define DFCP_STANDALONE_CYC 262144
// host register map and fields
`define DFCP_HA_CTRL 4'h0
`define DFCP_HA_PTR 4'h1
`define DFCP_HA_WDATA 4'h2
`define DFCP_HA_RDATA 4'h3
`define DFCP_HA_STATUS 4'h4
`define DFCP_HA_STRAP 4'h5
`define DFCP_CTRL_GO 0
`define DFCP_CTRL_DIR 1
`define DFCP_CTRL_FMT 2
`define DFCP_CTRL_DATA 3
`define DFCP_STRAP_RESET 2'h3
// host timing: one quarter of a bit period
`define DFCP_REF_NS 25
`define DFCP_QTR_NS 50
`define DFCP_QTR_CYC ((`DFCP_QTR_NS + `DFCP_REF_NS - 1) / `DFCP_REF_NS)
`endif

/* File: logic/dfcp_device.sv */
// converter end of the dual format control port
//
// Function
// - 8-bit pointer: step bit, reserved, register
// - step bit clear keeps pointer constant
// - step bit set advances pointer per byte
// - enable bit dedicates shared pins to port
// - enable halts stand-alone, loads all defaults
// - host should enable before stand-alone completes
// - enable write accepted any time after reset
// - two-wire default; select falling edge: four-wire
// - port runs asynchronous to audio clocks
// - two-wire address 10011 plus two strap pins
// - receiver acknowledges every byte in two-wire; the host leaves its read-data ack slot released
// - two-wire write: address, pointer, data, stop
// - two-wire read streams registers while acknowledged
// - four-wire samples data on rising bit clock
// - serial out floats unless shifting read data
// - four-wire write: address, pointer, data bytes
// - four-wire read streams registers while selected
// - enable and power-down bits in register 8
`timescale 1ns/1ps
`include "dfcp_consts.svh"
module dfcp_device
    import dfcp_pkg::*;
#(
    parameter int unsigned STANDALONE_CYCLES = `DFCP_STANDALONE_CYC,
    parameter dfcp_byte_t CHIP_ID = 8'h5A // arbitrary value
) (
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // control port pins
    dfcp_if.dev pins,
    // settings towards the converter core
    output logic [7:0] misc_ctrl,
    output logic port_enable_bit,
    output logic power_down_bit,
    output logic pins_dedicated,
    output logic four_wire_mode,
    // stand-alone power-up status
    output logic standalone_done,
    output logic standalone_halted
);
    logic [3:0] pin_s;
    logic [3:0] prev_ff;
    logic bclk_rise, bclk_fall, sel_fall, sel_rise;
    logic start_c, stop_c, frame_start, frame_end;
    logic four_wire_ff;
    dfcp_dev_state_e state_ff;
    logic [3:0] cnt_ff;
    logic [6:0] sh_ff;
    dfcp_byte_t rx_byte, ptr_ff, nxt_ptr, tx_ff;
    logic byte_done, addr_ok, ack_pend_ff, ack_drv_ff, out_ff;
    logic wr_go, port_enable_bit_set;
    dfcp_byte_t regs_ff [0:15];
    logic [18:0] sa_cnt_ff;
    logic sa_done_ff, sa_halt_ff;

    // pointer step: wraps within the register field
    function automatic dfcp_byte_t step_ptr(input dfcp_byte_t p);
        if (p[`DFCP_PTR_INC_BIT]) begin
            return {p[7:4], p[3:0] + 4'h1};
        end
        return p;
    endfunction

    function automatic dfcp_byte_t dflt(input logic [3:0] idx);
        case (idx)
            4'h2: return `DFCP_RST_R2;
            4'h3: return `DFCP_RST_R3;
            4'h4: return `DFCP_RST_R4;
            4'h5: return `DFCP_RST_R5;
            4'h6: return `DFCP_RST_R6;
            4'h7: return `DFCP_RST_R7;
            4'h8: return `DFCP_RST_R8;
            4'h9: return `DFCP_RST_R9;
            default: return 8'h00;
        endcase
    endfunction

    // unmapped indices read zero, identity is fixed
    function automatic dfcp_byte_t reg_value(input logic [3:0] idx);
        if (idx == `DFCP_REG_ID) begin
            return CHIP_ID;
        end
        if (idx < `DFCP_REG_FIRST_RW || idx > `DFCP_REG_LAST) begin
            return 8'h00;
        end
        return regs_ff[idx];
    endfunction

    // pins are asynchronous to every clock here
    dfcp_sync #(.W(4)) u_sync (
        .clk(link_clk),
        .rst(link_rst),
        .async_in({pins.port_bit_clock, pins.port_serial_in,
                   pins.addr_low_or_select_pin, pins.addr_high_pin}),
        .sync_out(pin_s)
    );

    // previous synced levels for edge detection
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            prev_ff <= 4'hF;
        end else begin
            prev_ff <= pin_s;
        end
    end

    assign bclk_rise = pin_s[3] && !prev_ff[3];
    assign bclk_fall = !pin_s[3] && prev_ff[3];
    assign sel_fall = !pin_s[1] && prev_ff[1];
    assign sel_rise = pin_s[1] && !prev_ff[1];
    // data edge while clock stays high marks start or stop
    assign start_c = pin_s[3] && prev_ff[3] && prev_ff[2] && !pin_s[2];
    assign stop_c = pin_s[3] && prev_ff[3] && !prev_ff[2] && pin_s[2];
    assign frame_start = sel_fall || (!four_wire_ff && start_c);
    assign frame_end = four_wire_ff ? sel_rise : stop_c;

    // format choice is sticky until reset
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            four_wire_ff <= 1'b0;
        end else if (sel_fall) begin
            four_wire_ff <= 1'b1;
        end
    end

    assign rx_byte = {sh_ff, pin_s[2]};
    assign byte_done = bclk_rise && cnt_ff == 4'h7 && state_ff != DFCP_D_IDLE;
    assign addr_ok = four_wire_ff ? rx_byte[7:1] == `DFCP_FW_ADDR
        : rx_byte[7:1] == {`DFCP_TW_ADDR_HI, pin_s[0], pin_s[1]};
    assign nxt_ptr = step_ptr(ptr_ff);

    // frame sequencer: bit count and transfer phase
    always_ff @(posedge link_clk) begin
        if (link_rst || frame_end) begin
            state_ff <= DFCP_D_IDLE;
            cnt_ff <= 4'h0;
        end else if (frame_start) begin
            state_ff <= DFCP_D_ADDR;
            cnt_ff <= 4'h0;
        end else if (bclk_rise && state_ff != DFCP_D_IDLE) begin
            if (cnt_ff == 4'h8) begin
                cnt_ff <= 4'h0;
                // a released line on the read ack ends the stream
                if (state_ff == DFCP_D_RDATA && pin_s[2]) begin
                    state_ff <= DFCP_D_IGNORE;
                end
            end else if (cnt_ff == 4'h7) begin
                cnt_ff <= four_wire_ff ? 4'h0 : 4'h8;
                unique case (state_ff)
                    DFCP_D_ADDR: begin
                        if (!addr_ok) begin
                            state_ff <= DFCP_D_IGNORE;
                        end else if (rx_byte[0]) begin
                            state_ff <= DFCP_D_RDATA;
                        end else begin
                            state_ff <= DFCP_D_PTR;
                        end
                    end
                    DFCP_D_PTR: state_ff <= DFCP_D_WDATA;
                    DFCP_D_IDLE, DFCP_D_WDATA, DFCP_D_RDATA,
                    DFCP_D_IGNORE: state_ff <= state_ff;
                endcase
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    // data sampled on rising bit clock in both formats
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            sh_ff <= 7'h00;
        end else if (bclk_rise && cnt_ff != 4'h8) begin
            sh_ff <= rx_byte[6:0];
        end
    end

    // pointer, read byte and acknowledge bookkeeping
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ptr_ff <= `DFCP_PTR_RESET;
            tx_ff <= 8'h00;
            ack_pend_ff <= 1'b0;
        end else if (byte_done) begin
            ack_pend_ff <= 1'b0;
            if (state_ff == DFCP_D_ADDR && addr_ok) begin
                ack_pend_ff <= 1'b1;
                tx_ff <= reg_value(ptr_ff[3:0]);
            end else if (state_ff == DFCP_D_PTR) begin
                // reserved pointer bits are held at zero
                ptr_ff <= {rx_byte[7], 3'h0, rx_byte[3:0]};
                ack_pend_ff <= 1'b1;
            end else if (state_ff == DFCP_D_WDATA) begin
                ptr_ff <= nxt_ptr;
                ack_pend_ff <= 1'b1;
            end else if (state_ff == DFCP_D_RDATA) begin
                ptr_ff <= nxt_ptr;
                tx_ff <= reg_value(nxt_ptr[3:0]);
            end
        end
    end

    assign wr_go = byte_done && state_ff == DFCP_D_WDATA;
    assign port_enable_bit_set = wr_go && ptr_ff[3:0] == `DFCP_REG_MISC &&
        rx_byte[`DFCP_MISC_EN_BIT] && !port_enable_bit;

    // register file; enable write is taken at any time
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            for (int i = 0; i < 16; i++) begin
                regs_ff[i] <= dflt(4'(i));
            end
        end else if (port_enable_bit_set) begin
            for (int i = 0; i < 16; i++) begin
                regs_ff[i] <= dflt(4'(i));
            end
            regs_ff[`DFCP_REG_MISC] <= rx_byte;
        end else if (wr_go && ptr_ff[3:0] >= `DFCP_REG_FIRST_RW &&
                     ptr_ff[3:0] <= `DFCP_REG_LAST) begin
            regs_ff[ptr_ff[3:0]] <= rx_byte;
        end
    end

    // line drive changes only on falling bit clock; outside a read
    // phase it stays released, else a stale bit fakes a start
    always_ff @(posedge link_clk) begin
        if (link_rst || frame_start || frame_end) begin
            out_ff <= 1'b1;
            ack_drv_ff <= 1'b0;
        end else if (bclk_fall) begin
            out_ff <= (cnt_ff < 4'h8 && state_ff == DFCP_D_RDATA) ?
                tx_ff[~cnt_ff[2:0]] : 1'b1;
            ack_drv_ff <= !four_wire_ff && cnt_ff == 4'h8 && ack_pend_ff;
        end
    end

    // open drain: only ever pulls the shared line low
    assign pins.dev_sda_o = 1'b0;
    assign pins.dev_sda_oe = !four_wire_ff && (ack_drv_ff ||
        (state_ff == DFCP_D_RDATA && !out_ff));
    assign pins.port_serial_out_o = out_ff;
    // release follows select by the synchroniser delay
    assign pins.port_serial_out_oe = four_wire_ff && pin_s[1] == 1'b0 &&
        state_ff == DFCP_D_RDATA;

    // stand-alone power-up timer, stopped by the enable bit
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            sa_cnt_ff <= 19'h00000;
            sa_done_ff <= 1'b0;
            sa_halt_ff <= 1'b0;
        end else begin
            if (port_enable_bit && !sa_done_ff) begin
                sa_halt_ff <= 1'b1;
            end
            if (!sa_halt_ff && !port_enable_bit && !sa_done_ff) begin
                sa_cnt_ff <= sa_cnt_ff + 19'h00001;
                if (sa_cnt_ff == 19'(STANDALONE_CYCLES - 1)) begin
                    sa_done_ff <= 1'b1;
                end
            end
        end
    end

    assign misc_ctrl = regs_ff[`DFCP_REG_MISC];
    assign port_enable_bit = misc_ctrl[`DFCP_MISC_EN_BIT];
    assign power_down_bit = misc_ctrl[`DFCP_MISC_PDN_BIT];
    assign pins_dedicated = port_enable_bit;
    assign four_wire_mode = four_wire_ff;
    assign standalone_done = sa_done_ff;
    assign standalone_halted = sa_halt_ff;
endmodule // dfcp_device

/* File: logic/dfcp_host.sv */
// host end of the dual format control port
`timescale 1ns/1ps
`include "dfcp_consts.svh"
module dfcp_host
    import dfcp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // control port pins
    dfcp_if.host pins
);
    localparam logic [3:0] QTR_LAST = 4'(`DFCP_QTR_CYC - 1);
    dfcp_host_state_e state_ff;
    logic [3:0] div_ff, bit_ff;
    logic [1:0] q_ff, bidx_ff, strap_ff;
    logic dir_ff, fmt_ff, data_ff, busy_ff, nack_ff, done_ff;
    dfcp_byte_t ptr_ff, wdata_ff, rdata_ff, rx_ff, cur_tx;
    logic [1:0] in_s;
    logic go, tick, in_bit, cur_rx, last_byte, tx_bit;
    logic bclk_ff, sel_ff, sda_o_ff, sda_oe_ff;

    dfcp_sync #(.W(2)) u_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .async_in({pins.port_serial_in, pins.port_serial_out}),
        .sync_out(in_s)
    );

    assign go = reg_wr && reg_addr == `DFCP_HA_CTRL &&
        reg_wdata[`DFCP_CTRL_GO] && !busy_ff;
    assign tick = div_ff == QTR_LAST;
    assign in_bit = fmt_ff ? in_s[0] : in_s[1];
    assign cur_rx = dir_ff && bidx_ff == 2'h1;
    assign last_byte = dir_ff ? bidx_ff == 2'h1
        : bidx_ff == (data_ff ? 2'h2 : 2'h1);
    assign cur_tx = bidx_ff == 2'h0 ? (fmt_ff ? {`DFCP_FW_ADDR, dir_ff}
        : {`DFCP_TW_ADDR_HI, strap_ff, dir_ff})
        : bidx_ff == 2'h1 ? ptr_ff : wdata_ff;
    // ack slot and read bits leave the line released
    assign tx_bit = bit_ff[3] || cur_rx || cur_tx[~bit_ff[2:0]];

    // software registers; settings frozen while busy
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            {dir_ff, fmt_ff, data_ff} <= 3'h0;
            ptr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            strap_ff <= `DFCP_STRAP_RESET;
        end else if (reg_wr && !busy_ff) begin
            if (go) begin
                dir_ff <= reg_wdata[`DFCP_CTRL_DIR];
                fmt_ff <= reg_wdata[`DFCP_CTRL_FMT];
                data_ff <= reg_wdata[`DFCP_CTRL_DATA];
            end
            if (reg_addr == `DFCP_HA_PTR) ptr_ff <= reg_wdata;
            if (reg_addr == `DFCP_HA_WDATA) wdata_ff <= reg_wdata;
            if (reg_addr == `DFCP_HA_STRAP) strap_ff <= reg_wdata[1:0];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `DFCP_HA_CTRL: reg_rdata <= {4'h0, data_ff, fmt_ff,
                                             dir_ff, 1'b0};
                `DFCP_HA_PTR: reg_rdata <= ptr_ff;
                `DFCP_HA_WDATA: reg_rdata <= wdata_ff;
                `DFCP_HA_RDATA: reg_rdata <= rdata_ff;
                `DFCP_HA_STATUS: reg_rdata <= {5'h00, done_ff, nack_ff,
                                               busy_ff};
                `DFCP_HA_STRAP: reg_rdata <= {6'h00, strap_ff};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // quarter bit divider; restarts with each transfer
    always_ff @(posedge ref_clk) begin
        if (sys_rst || go || tick) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    // bit sequencer and pin drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= DFCP_H_IDLE;
            {q_ff, bidx_ff, bit_ff} <= 8'h00;
            {busy_ff, nack_ff, done_ff} <= 3'h0;
            {bclk_ff, sel_ff, sda_o_ff} <= 3'h7;
            sda_oe_ff <= 1'b0;
            rx_ff <= 8'h00;
            rdata_ff <= 8'h00;
        end else if (go) begin
            state_ff <= DFCP_H_START;
            {q_ff, busy_ff, nack_ff, done_ff} <= 5'h04;
        end else if (tick) begin
            q_ff <= q_ff + 2'h1;
            unique case (state_ff)
                DFCP_H_IDLE: begin
                    // select line follows format and strap_ff[0] between transfers
                    sel_ff <= fmt_ff | strap_ff[0];
                    q_ff <= 2'h0;
                end
                DFCP_H_START: begin
                    if (q_ff == 2'h0) begin
                        bclk_ff <= !fmt_ff;
                        sel_ff <= fmt_ff ? 1'b0 : strap_ff[0];
                    end
                    // pull low while clock is high: the start condition
                    if (q_ff == 2'h1) begin
                        sda_o_ff <= 1'b0;
                        sda_oe_ff <= !fmt_ff;
                    end
                    if (q_ff == 2'h2) bclk_ff <= 1'b0;
                    if (q_ff == 2'h3) begin
                        state_ff <= DFCP_H_BYTE;
                        {bidx_ff, bit_ff} <= 6'h00;
                    end
                end
                DFCP_H_BYTE: begin
                    if (q_ff == 2'h0) begin
                        sda_o_ff <= fmt_ff ? tx_bit : 1'b0;
                        sda_oe_ff <= fmt_ff || !tx_bit;
                    end
                    if (q_ff == 2'h1) bclk_ff <= 1'b1;
                    if (q_ff == 2'h2 && !bit_ff[3]) begin
                        rx_ff <= {rx_ff[6:0], in_bit};
                    end
                    if (q_ff == 2'h2 && bit_ff[3] && !cur_rx && in_bit) begin
                        nack_ff <= 1'b1;
                    end
                    if (q_ff == 2'h3) begin
                        bclk_ff <= 1'b0;
                        if (bit_ff == (fmt_ff ? 4'h7 : 4'h8)) begin
                            bit_ff <= 4'h0;
                            bidx_ff <= bidx_ff + 2'h1;
                            if (last_byte || nack_ff) begin
                                state_ff <= DFCP_H_STOP;
                            end
                        end else begin
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end
                end
                DFCP_H_STOP: begin
                    if (q_ff == 2'h0) begin
                        sda_o_ff <= 1'b0;
                        sda_oe_ff <= !fmt_ff;
                        sel_ff <= fmt_ff | strap_ff[0];
                    end
                    if (q_ff == 2'h1) bclk_ff <= 1'b1;
                    if (q_ff == 2'h2) begin
                        {sda_o_ff, sda_oe_ff} <= 2'h2;
                    end
                    if (q_ff == 2'h3) begin
                        state_ff <= DFCP_H_IDLE;
                        {busy_ff, done_ff} <= 2'h1;
                        if (dir_ff) rdata_ff <= rx_ff;
                    end
                end
            endcase
        end
    end

    assign pins.port_bit_clock = bclk_ff;
    assign pins.addr_low_or_select_pin = sel_ff;
    assign pins.addr_high_pin = strap_ff[1];
    assign pins.host_sda_o = sda_o_ff;
    assign pins.host_sda_oe = sda_oe_ff;
endmodule // dfcp_host

/* File: logic/dfcp_if.sv */
// pins between the control port host and the converter device
`timescale 1ns/1ps
interface dfcp_if;
    logic port_bit_clock;
    logic addr_low_or_select_pin;
    logic addr_high_pin;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic port_serial_in;
    logic port_serial_out_o;
    logic port_serial_out_oe;
    logic port_serial_out;
    // shared data line: open drain with pull-up, any low driver wins
    assign port_serial_in = !((host_sda_oe && !host_sda_o) ||
                              (dev_sda_oe && !dev_sda_o));
    // released serial out reads high through its pull-up
    assign port_serial_out = port_serial_out_oe ? port_serial_out_o : 1'b1;
    modport dev (
        input port_bit_clock, addr_low_or_select_pin, addr_high_pin,
        input port_serial_in,
        output dev_sda_o, dev_sda_oe, port_serial_out_o, port_serial_out_oe
    );
    modport host (
        output port_bit_clock, addr_low_or_select_pin, addr_high_pin,
        output host_sda_o, host_sda_oe,
        input port_serial_in, port_serial_out
    );
endinterface

/* File: logic/dfcp_pkg.sv */
// types shared by both ends of the dual format control port
package dfcp_pkg;
    typedef logic [7:0] dfcp_byte_t;
    typedef enum logic [2:0] {
        DFCP_D_IDLE = 3'b000,
        DFCP_D_ADDR = 3'b001,
        DFCP_D_PTR = 3'b010,
        DFCP_D_WDATA = 3'b011,
        DFCP_D_RDATA = 3'b100,
        DFCP_D_IGNORE = 3'b101
    } dfcp_dev_state_e;
    typedef enum logic [1:0] {
        DFCP_H_IDLE = 2'b00,
        DFCP_H_START = 2'b01,
        DFCP_H_BYTE = 2'b10,
        DFCP_H_STOP = 2'b11
    } dfcp_host_state_e;
endpackage

/* File: logic/dfcp_sync.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module dfcp_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second; idle pin level is high
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule // dfcp_sync

/* File: tb/dfcp_properties.sv */
// pin-level assertions for the control port, link clock domain
`timescale 1ns/1ps
module dfcp_properties (
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // watched pins
    input wire logic port_bit_clock,
    input wire logic addr_low_or_select_pin,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic port_serial_out_o,
    input wire logic port_serial_out_oe
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (link_rst);
    open_drain_a: assert property (
        dev_sda_oe |-> !dev_sda_o) else $error("device drove sda high");
    out_release_a: assert property (
        $rose(addr_low_or_select_pin) |-> ##[0:6] !port_serial_out_oe)
        else $error("serial out not released");
    one_driver_a: assert property (
        !(dev_sda_oe && port_serial_out_oe)) else $error("both outputs on");
    out_selected_a: assert property (
        $rose(port_serial_out_oe) |-> !addr_low_or_select_pin)
        else $error("serial out without select");
    out_shift_a: assert property (
        port_serial_out_oe && $changed(port_serial_out_o) |-> !port_bit_clock)
        else $error("serial out moved on high clock");
    sda_edge_a: assert property (
        $changed(dev_sda_oe) |-> !port_bit_clock)
        else $error("sda moved on high clock");
    idle_release_a: assert property (
        addr_low_or_select_pin && $past(addr_low_or_select_pin, 3)
        |-> !port_serial_out_oe) else $error("serial out on while idle");
    ack_bound_a: assert property (
        $rose(dev_sda_oe) |-> ##[1:250] !dev_sda_oe)
        else $error("sda held too long");
    cover property ($rose(dev_sda_oe));
    cover property ($rose(port_serial_out_oe));
    cover property ($fell(addr_low_or_select_pin));
endmodule // dfcp_properties

/* File: tb/dual_format_control_port_tb_top.sv */
// bench joining host and device over the control port pins
`timescale 1ns/1ps
`include "dfcp_consts.svh"
module dual_format_control_port_tb_top;
    localparam logic [7:0] CHIP_ID_VAL = 8'h3C; // arbitrary id value
    logic ref_clk = 1'h0;
    logic link_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic link_rst = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata, misc_ctrl, st, rv;
    logic port_enable_bit, power_down_bit, pins_dedicated, four_wire_mode;
    logic standalone_done, standalone_halted;
    int mismatches = 0;
    int check_count = 0;
    dfcp_if bus ();
    // clocks: link offset so phases stay unrelated
    always #12.5 ref_clk = !ref_clk;
    initial #3 forever #6 link_clk = !link_clk;
    dfcp_host i_dfcp_host (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(bus.host));
    dfcp_device #(.STANDALONE_CYCLES(2000), .CHIP_ID(CHIP_ID_VAL))
    i_dfcp_device (.link_clk(link_clk), .link_rst(link_rst),
        .pins(bus.dev), .misc_ctrl(misc_ctrl),
        .port_enable_bit(port_enable_bit), .power_down_bit(power_down_bit),
        .pins_dedicated(pins_dedicated), .four_wire_mode(four_wire_mode),
        .standalone_done(standalone_done),
        .standalone_halted(standalone_halted));
    dfcp_properties i_dfcp_properties (.link_clk(link_clk),
        .link_rst(link_rst), .port_bit_clock(bus.port_bit_clock),
        .addr_low_or_select_pin(bus.addr_low_or_select_pin),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
        .port_serial_out_o(bus.port_serial_out_o),
        .port_serial_out_oe(bus.port_serial_out_oe));
    task automatic chk(input string n, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    // one link frame; poll bounded so a stuck sequencer cannot hang
    task automatic xfer(input logic [7:0] c, p, d);
        int n;
        wr(`DFCP_HA_PTR, p);
        wr(`DFCP_HA_WDATA, d);
        wr(`DFCP_HA_CTRL, c | 8'h01);
        n = 0;
        st = 8'h01;
        while (st[0] !== 1'h0 && n < 3000) begin
            rd(`DFCP_HA_STATUS, st);
            n++;
        end
        if (n == 3000)
            mismatches++;
    endtask
    task automatic rdchk(input logic [7:0] f, p, exp, input logic setp);
        if (setp)
            xfer(f, p, 8'h00);
        xfer(f | 8'h02, 8'h00, 8'h00);
        rd(`DFCP_HA_RDATA, rv);
        chk("read data", rv, exp);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge link_clk);
        link_rst <= 1'h0;
    end
    // whole run needs roughly 75 us; a hang is cut well beyond that
    initial begin
        #2000000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        rdchk(8'h00, 8'h08, `DFCP_RST_R8, 1'h1);
        chk("status", st, 8'h04);
        chk("mode", {misc_ctrl[7:1], four_wire_mode}, 8'h80);
        $display("defaults test done");
        xfer(8'h08, 8'h08, 8'hC0);
        chk("enable", {6'h00, port_enable_bit, pins_dedicated},
            8'h03);
        chk("halt", {6'h00, standalone_halted, standalone_done},
            8'h02);
        chk("misc", {power_down_bit, misc_ctrl[6:0]}, 8'hC0);
        $display("enable test done");
        xfer(8'h08, 8'h06, 8'h66);
        xfer(8'h08, 8'h85, 8'h11);
        rdchk(8'h00, 8'h00, 8'h66, 1'h0);
        rdchk(8'h00, 8'h00, `DFCP_RST_R7, 1'h0);
        xfer(8'h08, 8'h05, 8'h22);
        rdchk(8'h00, 8'h00, 8'h22, 1'h0);
        rdchk(8'h00, 8'h00, 8'h22, 1'h0);
        xfer(8'h08, 8'h01, 8'hFF);
        rdchk(8'h00, 8'h00, CHIP_ID_VAL, 1'h0);
        $display("pointer test done");
        wr(`DFCP_HA_STRAP, 8'h00);
        xfer(8'h00, 8'h00, 8'h00);
        // a falling strap edge on the select pin forces four-wire
        chk("status", st, 8'h06);
        chk("mode", {7'h0, four_wire_mode}, 8'h01);
        wr(`DFCP_HA_STRAP, 8'h03);
        $display("address test done");
        xfer(8'h0C, 8'h03, 8'h5C);
        rdchk(8'h04, 8'h03, 8'h5C, 1'h1);
        chk("mode", {7'h0, four_wire_mode}, 8'h01);
        rd(4'hF, rv);
        chk("unmapped", rv, 8'h00);
        $display("four wire test done");
        report_and_stop();
    end
endmodule // dual_format_control_port_tb_top
